// file: design/ivt_consts.vh
// Summary of operation
// RULE1: register reads and writes complete only after earlier write-queue entries drain.
// RULE2: a register read marks every valid write-queue entry as conflicting.
// RULE3: a register write enters the write queue behind all earlier writes.
// RULE4: a read of this unit returns one quadword, never a four-quadword block.
// RULE5: reading write-only or unimplemented registers returns arbitrary data, no error.
// RULE6: writes to unimplemented addresses inside the block are dropped silently.
// RULE7: writes outside the block are discarded; reads there return arbitrary data.
// RULE8: control/status, next-count and count sit at addresses 18, 19, 1A hex.
// RULE9: overflow with overflow flag already set sets missed flag bit 31, write-one clears.
// RULE10: each overflow sets flag bit 7 (write-one clears); interrupt if enable bit 6.
// RULE11: setting enable while the overflow flag is set raises interrupt at once.
// RULE12: reset clears interrupt enable and run bits.
// RULE13: software writes zero to reserved bits 30:8 and 3:1.
// RULE14: with run clear, each single-step write increments the count by one.
// RULE15: single-step is ignored when run is set or transfer is written together.
// RULE16: each transfer write copies next-count into count.
// RULE17: single-step and transfer bits are pulses and read as zero.
// RULE18: with run set the count increments once per microsecond, else holds.
// RULE19: on overflow count reloads from next-count; next-count stays unchanged.
// RULE20: reset clears next-count to zero.
// RULE21: after reload the count keeps incrementing without pause.
// RULE22: count is read-only and cleared by reset.
// RULE23: a core-clock prescaler makes exactly one count enable per microsecond.
`ifndef IVT_CONSTS_VH
`define IVT_CONSTS_VH

`define IVT_ADDR_W        8
`define IVT_ADDR_CSR      8'h18
`define IVT_ADDR_NEXT     8'h19
`define IVT_ADDR_COUNT    8'h1A
`define IVT_BLOCK_LO      8'h18
`define IVT_BLOCK_HI      8'hB0
`define IVT_BIT_MISSED    31
`define IVT_BIT_FLAG      7
`define IVT_BIT_IE        6
`define IVT_BIT_SGL       5
`define IVT_BIT_XFR       4
`define IVT_BIT_RUN       0
`define IVT_TICK_NS       1000
`define IVT_CLK_NS        40
`define IVT_TICK_CYCLES   (`IVT_TICK_NS / `IVT_CLK_NS)
`define IVT_WQ_DEPTH      8

`endif

// file: design/ivt_prescaler.v
`timescale 1ns/1ns
`default_nettype none
`include "ivt_consts.vh"

module ivt_prescaler #(
    parameter integer DIVIDE = `IVT_TICK_CYCLES
) (
    // clock and reset
    input  wire       clk_i,
    input  wire       nrst_i,
    // one cycle per microsecond
    output wire       tick_o
);
    reg  [7:0] cnt_ff;
    wire [7:0] last = DIVIDE[7:0] - 8'h01;

    // free-running divider; free so the run bit never shifts the phase grid
    always @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cnt_ff <= 8'h00;
        end else if (cnt_ff == last) begin
            cnt_ff <= 8'h00;
        end else begin
            cnt_ff <= cnt_ff + 8'h01;
        end
    end

    assign tick_o = (cnt_ff == last); // RULE23
endmodule
`default_nettype wire

// file: design/ivt_write_queue.v
`timescale 1ns/1ns
`default_nettype none
`include "ivt_consts.vh"

module ivt_write_queue #(
    parameter integer DEPTH = `IVT_WQ_DEPTH,
    parameter integer AW    = 3
) (
    // clock and reset
    input  wire        clk_i,
    input  wire        nrst_i,
    // fill side
    input  wire        push_i,
    input  wire        push_reg_i,
    input  wire [7:0]  push_addr_i,
    input  wire [31:0] push_data_i,
    output wire        full_o,
    // marks all valid entries as conflicting
    input  wire        conflict_i,
    // drain side
    output wire        head_valid_o,
    output wire        head_reg_o,
    output wire [7:0]  head_addr_o,
    output wire [31:0] head_data_o,
    input  wire        pop_i,
    // status
    output wire        empty_o,
    output wire        conflict_o
);
    reg [40:0]   mem_ff [0:DEPTH-1];
    reg [DEPTH-1:0] cfl_ff;
    reg [AW-1:0] wr_ff;
    reg [AW-1:0] rd_ff;
    reg [AW:0]   cnt_ff;
    integer      i;

    wire do_push = push_i && !full_o;
    wire do_pop  = pop_i && head_valid_o;

    assign full_o       = (cnt_ff == DEPTH);
    assign empty_o      = (cnt_ff == 0);
    assign head_valid_o = !empty_o;
    assign head_reg_o   = mem_ff[rd_ff][40];
    assign head_addr_o  = mem_ff[rd_ff][39:32];
    assign head_data_o  = mem_ff[rd_ff][31:0];
    assign conflict_o   = |cfl_ff;

    // storage; entries keep arrival order so a register write lands behind prior writes
    always @(posedge clk_i) begin
        if (do_push) begin
            mem_ff[wr_ff] <= {push_reg_i, push_addr_i, push_data_i}; // RULE3
        end
    end

    // pointers and conflict bits
    always @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            wr_ff  <= {AW{1'b0}};
            rd_ff  <= {AW{1'b0}};
            cnt_ff <= {(AW+1){1'b0}};
            cfl_ff <= {DEPTH{1'b0}};
        end else begin
            if (do_push) begin
                wr_ff <= wr_ff + 1'b1;
            end
            if (do_pop) begin
                rd_ff <= rd_ff + 1'b1;
            end
            cnt_ff <= cnt_ff + {{AW{1'b0}}, do_push} - {{AW{1'b0}}, do_pop};
            for (i = 0; i < DEPTH; i = i + 1) begin
                if (do_pop && rd_ff == i) begin
                    cfl_ff[i] <= 1'b0;
                end else if (conflict_i && (cnt_ff > ((i - rd_ff) & (DEPTH - 1)))) begin
                    cfl_ff[i] <= 1'b1; // RULE2
                end
            end
        end
    end
endmodule
`default_nettype wire

// file: design/interval_timer_ipr_unit.v
`timescale 1ns/1ns
`default_nettype none
`include "ivt_consts.vh"

module interval_timer_ipr_unit #(
    parameter integer TICK_CYCLES = `IVT_TICK_CYCLES,
    parameter integer WQ_DEPTH    = `IVT_WQ_DEPTH
) (
    // clock and reset
    input  wire        clk_i,
    input  wire        nrst_i,
    // memory writes entering the write queue
    input  wire        mem_wr_req_i,
    input  wire [7:0]  mem_wr_addr_i,
    input  wire [31:0] mem_wr_data_i,
    output wire        mem_wr_ready_o,
    // write-queue drain toward memory
    output wire        mem_out_valid_o,
    output wire [7:0]  mem_out_addr_o,
    output wire [31:0] mem_out_data_o,
    input  wire        mem_out_ready_i,
    // internal-register commands from the memory-management unit
    input  wire        ipr_req_i,
    input  wire        ipr_write_i,
    input  wire [7:0]  ipr_addr_i,
    input  wire [31:0] ipr_wdata_i,
    output wire        ipr_ready_o,
    output reg         ipr_done_o,
    output reg  [63:0] ipr_rdata_o,
    // timer interrupt request
    output wire        timer_irq_o,
    // conflict seen on queued writes
    output wire        wq_conflict_o
);
    ////////////////////////////////////////////////////////////////////////////
    // command sequencer
    localparam [1:0] ST_IDLE  = 2'd0;
    localparam [1:0] ST_DRAIN = 2'd1;
    localparam [1:0] ST_ANS   = 2'd2;

    reg  [1:0]  state_ff;
    reg  [1:0]  nxt_state;
    reg  [7:0]  rd_addr_ff;
    reg         rd_pending_ff;

    // control/status and counters
    reg         missed_ff;
    reg         flag_ff;
    reg         ie_ff;
    reg         run_ff;
    reg  [31:0] next_ff;
    reg  [31:0] count_ff;
    reg         irq_ff;

    wire        tick;
    wire        wq_full;
    wire        wq_empty;
    wire        head_valid;
    wire        head_reg;
    wire [7:0]  head_addr;
    wire [31:0] head_data;
    wire        head_pop;

    // block range test used by the write decode only
    function in_block;
        input [7:0] a;
        begin
            in_block = (a >= `IVT_BLOCK_LO) && (a <= `IVT_BLOCK_HI);
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // shared write queue
    wire take_ipr_wr = (state_ff == ST_IDLE) && ipr_req_i && ipr_write_i && !wq_full;
    wire take_ipr_rd = (state_ff == ST_IDLE) && ipr_req_i && !ipr_write_i;
    wire take_mem    = mem_wr_req_i && !take_ipr_wr;

    ivt_write_queue #(
        .DEPTH (WQ_DEPTH),
        .AW    (3)
    ) u_wq (
        .clk_i        (clk_i),
        .nrst_i       (nrst_i),
        .push_i       (take_ipr_wr || take_mem),
        .push_reg_i   (take_ipr_wr),
        .push_addr_i  (take_ipr_wr ? ipr_addr_i : mem_wr_addr_i),
        .push_data_i  (take_ipr_wr ? ipr_wdata_i : mem_wr_data_i),
        .full_o       (wq_full),
        .conflict_i   (take_ipr_rd), // RULE2
        .head_valid_o (head_valid),
        .head_reg_o   (head_reg),
        .head_addr_o  (head_addr),
        .head_data_o  (head_data),
        .pop_i        (head_pop),
        .empty_o      (wq_empty),
        .conflict_o   (wq_conflict_o)
    );

    // memory writes stall while a register write takes the slot or the queue is full
    assign mem_wr_ready_o  = !wq_full && !take_ipr_wr;
    assign mem_out_valid_o = head_valid && !head_reg;
    assign mem_out_addr_o  = head_addr;
    assign mem_out_data_o  = head_data;
    // register entries retire here in one cycle, memory entries when memory accepts
    assign head_pop        = head_valid && (head_reg || mem_out_ready_i);
    assign ipr_ready_o     = (state_ff == ST_IDLE) && !(ipr_write_i && wq_full);

    ////////////////////////////////////////////////////////////////////////////
    // register write decode at the head of the queue
    wire reg_wr   = head_valid && head_reg && in_block(head_addr); // RULE7
    wire wr_csr   = reg_wr && (head_addr == `IVT_ADDR_CSR);  // RULE8
    wire wr_next  = reg_wr && (head_addr == `IVT_ADDR_NEXT); // RULE8
    // other in-block addresses fall through with no effect
    wire wr_xfr   = wr_csr && head_data[`IVT_BIT_XFR];                       // RULE16
    wire wr_sgl   = wr_csr && head_data[`IVT_BIT_SGL] && !head_data[`IVT_BIT_XFR]
                    && !run_ff;                                              // RULE15
    wire run_inc  = run_ff && tick;                                          // RULE18
    wire overflow = (run_inc || wr_sgl) && (count_ff == 32'hFFFFFFFF) && !wr_xfr;

    ivt_prescaler #(
        .DIVIDE (TICK_CYCLES)
    ) u_pre (
        .clk_i  (clk_i),
        .nrst_i (nrst_i),
        .tick_o (tick)
    );

    ////////////////////////////////////////////////////////////////////////////
    // control/status bits; a hardware set wins over a same-cycle write-one clear
    always @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ie_ff     <= 1'b0; // RULE12
            run_ff    <= 1'b0; // RULE12
            flag_ff   <= 1'b0;
            missed_ff <= 1'b0;
        end else begin
            if (wr_csr) begin
                ie_ff  <= head_data[`IVT_BIT_IE];
                run_ff <= head_data[`IVT_BIT_RUN];
            end
            if (overflow) begin
                flag_ff <= 1'b1; // RULE10
            end else if (wr_csr && head_data[`IVT_BIT_FLAG]) begin
                flag_ff <= 1'b0; // RULE10
            end
            if (overflow && flag_ff) begin
                missed_ff <= 1'b1; // RULE9
            end else if (wr_csr && head_data[`IVT_BIT_MISSED]) begin
                missed_ff <= 1'b0; // RULE9
            end
        end
    end

    // interrupt level follows flag and enable one cycle later; enabling over a set flag fires the cycle after enable sets
    always @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            irq_ff <= 1'b0;
        end else begin
            irq_ff <= flag_ff && ie_ff; // RULE11
        end
    end
    assign timer_irq_o = irq_ff; // RULE10

    ////////////////////////////////////////////////////////////////////////////
    // next-count and count registers
    always @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            next_ff  <= 32'h00000000; // RULE20
            count_ff <= 32'h00000000; // RULE22
        end else begin
            if (wr_next) begin
                next_ff <= head_data;
            end
            if (wr_xfr) begin
                count_ff <= next_ff; // RULE16
            end else if (overflow) begin
                count_ff <= next_ff; // RULE19 RULE21
            end else if (run_inc || wr_sgl) begin
                count_ff <= count_ff + 32'h00000001; // RULE14 RULE18
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read answer data; pulses and reserved bits read zero, count has no write path
    function [31:0] read_mux;
        input [7:0] a;
        begin
            case (a)
                `IVT_ADDR_CSR:   read_mux = {missed_ff, 23'h000000, flag_ff, ie_ff,
                                             2'b00, 3'b000, run_ff}; // RULE17
                `IVT_ADDR_NEXT:  read_mux = next_ff;
                `IVT_ADDR_COUNT: read_mux = count_ff; // RULE22
                default:         read_mux = 32'h00000000; // RULE5 RULE7
            endcase
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // sequencer: reads and writes both wait for a fully drained queue
    always @* begin
        nxt_state = state_ff;
        case (state_ff)
            ST_IDLE: begin
                if (take_ipr_wr || take_ipr_rd) begin
                    nxt_state = ST_DRAIN;
                end
            end
            ST_DRAIN: begin
                if (wq_empty) begin
                    nxt_state = ST_ANS; // RULE1
                end
            end
            ST_ANS: begin
                nxt_state = ST_IDLE;
            end
            default: begin
                nxt_state = ST_IDLE;
            end
        endcase
    end

    always @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state_ff      <= ST_IDLE;
            rd_addr_ff    <= 8'h00;
            rd_pending_ff <= 1'b0;
            ipr_done_o    <= 1'b0;
            ipr_rdata_o   <= 64'h0000000000000000;
        end else begin
            state_ff   <= nxt_state;
            ipr_done_o <= 1'b0;
            if (take_ipr_wr || take_ipr_rd) begin
                rd_addr_ff    <= ipr_addr_i;
                rd_pending_ff <= take_ipr_rd;
            end
            if (state_ff == ST_ANS) begin
                ipr_done_o <= 1'b1; // RULE1
                if (rd_pending_ff) begin
                    // single quadword answer, upper half zero
                    ipr_rdata_o <= {32'h00000000, read_mux(rd_addr_ff)}; // RULE4
                end
            end
        end
    end
endmodule
`default_nettype wire

// file: verif/ivt_checker_assertions.sv
`timescale 1ns/1ns
`default_nettype none
module ivt_checker (
    // clock and reset
    input wire logic        clk_i,
    input wire logic        nrst_i,
    // memory side
    input wire logic        mem_wr_req_i,
    input wire logic [7:0]  mem_wr_addr_i,
    input wire logic        mem_wr_ready_o,
    input wire logic        mem_out_valid_o,
    input wire logic [7:0]  mem_out_addr_o,
    input wire logic [31:0] mem_out_data_o,
    input wire logic        mem_out_ready_i,
    // register commands
    input wire logic        ipr_req_i,
    input wire logic        ipr_write_i,
    input wire logic        ipr_ready_o,
    input wire logic        ipr_done_o,
    input wire logic [63:0] ipr_rdata_o,
    input wire logic        wq_conflict_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!nrst_i);
    // a command is taken when a request meets an idle sequencer, except a write while the queue is full
    wire take;
    assign take = ipr_req_i && ipr_ready_o;
    a_done_pulse: assert property (ipr_done_o |=> !ipr_done_o) else $error("done wider than one cycle");
    a_min_latency: assert property (take |=> !ipr_done_o [*2]) else $error("command done too early");
    a_one_command: assert property (take |=> !ipr_ready_o) else $error("second command accepted");
    a_stalled_head: assert property (mem_out_valid_o && !mem_out_ready_i && wq_conflict_o |-> !ipr_done_o)
        else $error("done before queue drained");
    a_read_conflict: assert property (take && !ipr_write_i && mem_out_valid_o |=> wq_conflict_o)
        else $error("read did not mark queue");
    a_write_queued: assert property (take && ipr_write_i |-> !mem_wr_ready_o) else $error("write not queued");
    a_head_hold: assert property (mem_out_valid_o && !mem_out_ready_i |=> mem_out_valid_o
        && $stable(mem_out_addr_o) && $stable(mem_out_data_o)) else $error("queue head changed");
    a_mem_enqueue: assert property (mem_wr_req_i && mem_wr_ready_o && ipr_ready_o && !mem_out_valid_o
        |=> mem_out_valid_o && mem_out_addr_o == $past(mem_wr_addr_i)) else $error("write lost");
    a_one_quadword: assert property (ipr_done_o |-> ipr_rdata_o[63:32] == 32'h0) else $error("wide read");
    a_rdata_hold: assert property (!ipr_done_o |-> $stable(ipr_rdata_o)) else $error("read data moved");
endmodule
`default_nettype wire

// file: verif/ivt_mem_sink.sv
`timescale 1ns/1ns
`default_nettype none
module ivt_mem_sink (
    // clock and reset
    input wire logic        clk_i,
    input wire logic        nrst_i,
    // queue head and bench control
    input wire logic        stall_i,
    input wire logic        valid_i,
    output logic            ready_o,
    output logic [7:0]      taken_o
);
    logic       ready_ff;
    logic [7:0] taken_ff;
    // memory may hold off for any time; ready moves off the sampling edge
    always @(negedge clk_i or negedge nrst_i) begin
        if (!nrst_i) ready_ff <= 1'b0;
        else ready_ff <= !stall_i;
    end
    // drained entries, so the bench can see queued writes leave
    always @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) taken_ff <= 8'h00;
        else if (valid_i && ready_ff) taken_ff <= taken_ff + 8'h01;
    end
    assign ready_o = ready_ff;
    assign taken_o = taken_ff;
endmodule
`default_nettype wire

// file: verif/tb_interval_timer_ipr_unit.sv
`timescale 1ns/1ns
`default_nettype none
`include "ivt_consts.vh"
module tb_interval_timer_ipr_unit;
    // short prescaler keeps the run brief
    localparam integer TICK = 4;
    logic        clk_i = 0, nrst_i = 0, mem_wr_req_i = 0, ipr_req_i = 0, ipr_write_i = 0, stall = 0;
    logic [7:0]  mem_wr_addr_i = 8'h00, ipr_addr_i = 8'h00;
    logic [31:0] mem_wr_data_i = 32'h0, ipr_wdata_i = 32'h0;
    logic [63:0] rd, c;
    wire         mem_wr_ready_o, mem_out_valid_o, mem_out_ready_i, ipr_ready_o, ipr_done_o, timer_irq_o;
    wire         wq_conflict_o;
    wire [7:0]   mem_out_addr_o, taken;
    wire [31:0]  mem_out_data_o;
    wire [63:0]  ipr_rdata_o;
    int          failures = 0, checks = 0, cycles = 0;
    interval_timer_ipr_unit #(.TICK_CYCLES(TICK), .WQ_DEPTH(8)) u_dut (.clk_i(clk_i), .nrst_i(nrst_i),
        .mem_wr_req_i(mem_wr_req_i), .mem_wr_addr_i(mem_wr_addr_i), .mem_wr_data_i(mem_wr_data_i),
        .mem_wr_ready_o(mem_wr_ready_o), .mem_out_valid_o(mem_out_valid_o), .mem_out_addr_o(mem_out_addr_o),
        .mem_out_data_o(mem_out_data_o), .mem_out_ready_i(mem_out_ready_i), .ipr_req_i(ipr_req_i),
        .ipr_write_i(ipr_write_i), .ipr_addr_i(ipr_addr_i), .ipr_wdata_i(ipr_wdata_i), .ipr_ready_o(ipr_ready_o),
        .ipr_done_o(ipr_done_o), .ipr_rdata_o(ipr_rdata_o), .timer_irq_o(timer_irq_o),
        .wq_conflict_o(wq_conflict_o));
    ivt_mem_sink u_mem (.clk_i(clk_i), .nrst_i(nrst_i), .stall_i(stall), .valid_i(mem_out_valid_o),
        .ready_o(mem_out_ready_i), .taken_o(taken));
    initial forever #20 clk_i = ~clk_i;
    // hang guard, well above the length of all tests
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            $display("Error at %0t: got %h expected %h", $time, cycles, 0);
            stop_test;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    task stop_test;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task chk(input logic [63:0] got, input logic [63:0] exp);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // request held until the edge that takes it, then released
    task issue(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(negedge clk_i);
        ipr_req_i = 1'b1; ipr_write_i = w; ipr_addr_i = a; ipr_wdata_i = d;
        n = 0;
        while (ipr_ready_o !== 1'b1 && n < 100) begin @(negedge clk_i); n++; end
        @(negedge clk_i);
        ipr_req_i = 1'b0;
    endtask
    task wait_done;
        int n;
        n = 0;
        while (ipr_done_o !== 1'b1 && n < 1000) begin @(negedge clk_i); n++; end
        if (n == 1000) chk(1'b0, 1'b1);
        rd = ipr_rdata_o;
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d); issue(1'b1, a, d); wait_done; endtask
    task rdr(input logic [7:0] a); issue(1'b0, a, 32'h0); wait_done; endtask
    ////////////////////////////////////////////////////////////////////////
    task t_reset;
        rdr(`IVT_ADDR_CSR); chk(rd, 64'h0);
        rdr(`IVT_ADDR_NEXT); chk(rd, 64'h0);
        rdr(`IVT_ADDR_COUNT); chk(rd, 64'h0);
        $display("test reset finished");
    endtask
    task t_map;
        wr(`IVT_ADDR_NEXT, 32'h12345678); rdr(`IVT_ADDR_NEXT); chk(rd, 64'h12345678);
        wr(`IVT_ADDR_COUNT, 32'h000000FF); rdr(`IVT_ADDR_COUNT); chk(rd, 64'h0);
        wr(8'h1B, 32'hFFFFFFFF); wr(8'hC0, 32'hFFFFFFFF); rdr(8'hC0);
        rdr(`IVT_ADDR_NEXT); chk(rd, 64'h12345678);
        rdr(`IVT_ADDR_CSR); chk(rd, 64'h0);
        $display("test map finished");
    endtask
    task t_step;
        repeat (3) wr(`IVT_ADDR_CSR, 32'h20);
        rdr(`IVT_ADDR_COUNT); chk(rd, 64'h3);
        wr(`IVT_ADDR_CSR, 32'h30); rdr(`IVT_ADDR_COUNT); chk(rd, 64'h12345678);
        wr(`IVT_ADDR_CSR, 32'h20); wr(`IVT_ADDR_CSR, 32'h10); rdr(`IVT_ADDR_COUNT); chk(rd, 64'h12345678);
        rdr(`IVT_ADDR_CSR); chk(rd, 64'h0);
        $display("test step finished");
    endtask
    task t_irq;
        wr(`IVT_ADDR_NEXT, 32'hFFFFFFFF); wr(`IVT_ADDR_CSR, 32'h10); wr(`IVT_ADDR_CSR, 32'h20);
        rdr(`IVT_ADDR_CSR); chk(rd, 64'h80);
        chk(timer_irq_o, 1'b0);
        wr(`IVT_ADDR_CSR, 32'h20); rdr(`IVT_ADDR_CSR); chk(rd, 64'h80000080);
        rdr(`IVT_ADDR_NEXT); chk(rd, 64'hFFFFFFFF);
        wr(`IVT_ADDR_CSR, 32'h40); chk(timer_irq_o, 1'b1);
        wr(`IVT_ADDR_CSR, 32'h800000C0);
        rdr(`IVT_ADDR_CSR); chk(rd, 64'h40);
        chk(timer_irq_o, 1'b0);
        $display("test irq finished");
    endtask
    task t_run;
        int n;
        wr(`IVT_ADDR_NEXT, 32'hFFFFFFFE); wr(`IVT_ADDR_CSR, 32'h10); wr(`IVT_ADDR_CSR, 32'h41);
        n = 0;
        while (timer_irq_o !== 1'b1 && n < 100) begin @(negedge clk_i); n++; end
        chk(timer_irq_o, 1'b1);
        wr(`IVT_ADDR_CSR, 32'h40); rdr(`IVT_ADDR_COUNT); c = rd;
        chk(c[63:1], 63'h7FFFFFFF);
        repeat (TICK * 4) @(negedge clk_i);
        rdr(`IVT_ADDR_COUNT); chk(rd, c);
        wr(`IVT_ADDR_NEXT, 32'h0); wr(`IVT_ADDR_CSR, 32'h10); wr(`IVT_ADDR_CSR, 32'h1);
        repeat (TICK * 20) @(negedge clk_i);
        wr(`IVT_ADDR_CSR, 32'h80000080); rdr(`IVT_ADDR_COUNT);
        // run stays set for 85 edges, so a 4-cycle tick grid lands 21 or 22 times
        chk({63'h0, rd >= 64'd21 && rd <= 64'd22}, 64'h1);
        $display("test run finished");
    endtask
    task t_order;
        int early;
        stall = 1'b1;
        @(negedge clk_i);
        mem_wr_req_i = 1'b1; mem_wr_addr_i = 8'h55; mem_wr_data_i = 32'hA5A5A5A5;
        @(negedge clk_i);
        mem_wr_req_i = 1'b0;
        issue(1'b0, `IVT_ADDR_CSR, 32'h0);
        early = 0;
        repeat (20) begin @(negedge clk_i); if (ipr_done_o === 1'b1) early++; end
        chk(early, 0);
        chk(wq_conflict_o, 1'b1);
        stall = 1'b0;
        wait_done;
        chk(taken, 8'h01);
        $display("test order finished");
    endtask
    initial begin
        repeat (3) @(negedge clk_i);
        nrst_i = 1'b1;
        t_reset;
        t_map;
        t_step;
        t_irq;
        t_run;
        t_order;
        stop_test;
    end
endmodule
bind interval_timer_ipr_unit ivt_checker u_chk (.clk_i(clk_i), .nrst_i(nrst_i), .mem_wr_req_i(mem_wr_req_i),
    .mem_wr_addr_i(mem_wr_addr_i), .mem_wr_ready_o(mem_wr_ready_o), .mem_out_valid_o(mem_out_valid_o),
    .mem_out_addr_o(mem_out_addr_o), .mem_out_data_o(mem_out_data_o), .mem_out_ready_i(mem_out_ready_i),
    .ipr_req_i(ipr_req_i), .ipr_write_i(ipr_write_i), .ipr_ready_o(ipr_ready_o), .ipr_done_o(ipr_done_o),
    .ipr_rdata_o(ipr_rdata_o), .wq_conflict_o(wq_conflict_o));
`default_nettype wire
